// ==== rtl/fmp_field_fifo.v ====
`timescale 1ns/1ps
`include "fmp_regs.vh"

// Summary of operation
// - Read reset deferred until gate enabled
// - Strap high makes all eight active low
// - Write bytes taken on write clock edges
// - Write reset zeroes write pointer
// - Gate advances pointer; mask decides storing
// - Gate off, no reset: no write, pointer held
// - Read data registered on read clock edges
// - Reset plus gate: pointer zero, word 0
// - Reset without gate: hold, reset later
// - Gate advances pointer; enable only gates pins
// - No reset, no gate: hold pointer, word
// - Read advance depends on gate and on no reset, current or pending
module fmp_field_fifo #(
  parameter DATA_W = `FMP_DATA_W,
  parameter ADDR_W = `FMP_ADDR_W
) (
  input  wire              clk_in,                  // System clock, 250 MHz
  input  wire              rst_b_in,                // Chip reset, synchronous, active low
  input  wire              polarity_strap_in,       // High: control and flag pins active low
  input  wire              write_clock_in,          // Write port clock pin
  input  wire              write_pointer_reset_in,  // Write pointer reset pin
  input  wire              write_gate_in,           // Write cycle enable pin
  input  wire              input_store_enable_in,   // Store enable (mask) pin
  input  wire [DATA_W-1:0] wr_data_in,              // Write data pins
  input  wire              read_clock_in,           // Read port clock pin
  input  wire              read_pointer_reset_in,   // Read pointer reset pin
  input  wire              read_gate_in,            // Read cycle enable pin
  input  wire              output_enable_in,        // Data pin drive enable pin
  output wire [DATA_W-1:0] rd_data_out,             // Read data pins, output value
  output wire              rd_data_oe_b_out,        // Low while data pins are driven
  output wire              input_space_flag_out,    // Space available flag pin
  output wire              output_data_flag_out     // New data available flag pin
);

  localparam SYNC_W = 5 + DATA_W;
  localparam RD_W   = 4;

  // Pointer constants cut to the pointer width on purpose
  localparam [`FMP_ADDR_W-1:0] PTR_ZERO_FULL = `FMP_PTR_ZERO;
  localparam [`FMP_ADDR_W-1:0] PTR_STEP_FULL = `FMP_PTR_STEP;
  localparam [ADDR_W-1:0]      PTR_ZERO      = PTR_ZERO_FULL[ADDR_W-1:0];
  localparam [ADDR_W-1:0]      PTR_STEP      = PTR_STEP_FULL[ADDR_W-1:0];

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [SYNC_W-1:0] wr_pins_sync;
  wire [RD_W-1:0]   rd_pins_sync;
  wire              strap_sync;

  // Write clock and its controls share one chain so they stay aligned
  fmp_sync #(
    .W (SYNC_W)
  ) u_wr_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({write_clock_in, write_pointer_reset_in, write_gate_in,
                input_store_enable_in, polarity_strap_in, wr_data_in}),
    .q_out    (wr_pins_sync)
  );

  // Read clock and its controls share one chain
  fmp_sync #(
    .W (RD_W)
  ) u_rd_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({read_clock_in, read_pointer_reset_in, read_gate_in, output_enable_in}),
    .q_out    (rd_pins_sync)
  );

  wire              wck_s    = wr_pins_sync[SYNC_W-1];
  wire              write_pointer_reset_s   = wr_pins_sync[SYNC_W-2];
  wire              wgate_s  = wr_pins_sync[SYNC_W-3];
  wire              wstore_s = wr_pins_sync[SYNC_W-4];
  wire [DATA_W-1:0] wdata_s  = wr_pins_sync[DATA_W-1:0];
  wire              rck_s    = rd_pins_sync[3];
  wire              read_pointer_reset_s   = rd_pins_sync[2];
  wire              rgate_s  = rd_pins_sync[1];
  wire              roe_s    = rd_pins_sync[0];

  assign strap_sync = wr_pins_sync[DATA_W];

  // ---------------------------------------------------------------
  // Strap capture and polarity
  // ---------------------------------------------------------------
  reg                        strap_ff;
  reg  [`FMP_SETTLE_LEN-1:0] settle_ff;
  wire                       settled;
  wire                       act_low;

  // Marks the cycles after reset while the chains still hold reset zeros
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      settle_ff <= {`FMP_SETTLE_LEN{1'b0}};
    end else begin
      settle_ff <= {settle_ff[`FMP_SETTLE_LEN-2:0], 1'b1};
    end
  end

  // Edges are trusted only once real pin levels fill every stage; strap loads one cycle sooner
  assign settled = settle_ff[`FMP_SETTLE_LEN-1];

  // Strap loads once the chain carries the real pin; pulled-up level until then
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      strap_ff <= `FMP_STRAP_RST;
    end else if (settle_ff[`FMP_SETTLE_LEN-2]) begin
      strap_ff <= strap_sync;
    end
  end

  assign act_low = (strap_ff == `FMP_STRAP_ACT_LOW);

  // Asserted levels of the six control inputs
  wire write_pointer_reset_act   = write_pointer_reset_s   ^ act_low;
  wire wgate_act  = wgate_s  ^ act_low;
  wire wstore_act = wstore_s ^ act_low;
  wire read_pointer_reset_act   = read_pointer_reset_s   ^ act_low;
  wire rgate_act  = rgate_s  ^ act_low;
  wire roe_act    = roe_s    ^ act_low;

  // ---------------------------------------------------------------
  // Port clock edge detection
  // ---------------------------------------------------------------
  reg  wck_d_ff;
  reg  rck_d_ff;
  wire wr_edge;
  wire rd_edge;

  // Previous synchronised clock levels
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      wck_d_ff <= `FMP_SYNC_RST;
      rck_d_ff <= `FMP_SYNC_RST;
    end else begin
      wck_d_ff <= wck_s;
      rck_d_ff <= rck_s;
    end
  end

  // Rising edges; no false edge from a pin that idles high at reset release
  assign wr_edge = wck_s & ~wck_d_ff & settled;
  assign rd_edge = rck_s & ~rck_d_ff & settled;

  // ---------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------
  reg  [ADDR_W-1:0] wptr_ff;
  reg  [ADDR_W-1:0] nxt_wptr;
  reg               mem_we;

  // Write pointer and store strobe decode
  always @* begin
    nxt_wptr = wptr_ff;
    mem_we   = 1'b0;
    if (wr_edge) begin
      if (write_pointer_reset_act) begin
        nxt_wptr = PTR_ZERO;
      end else if (wgate_act) begin
        nxt_wptr = wptr_ff + PTR_STEP;
        mem_we   = wstore_act;
      end else begin
        nxt_wptr = wptr_ff;
      end
    end
  end

  // Write pointer register
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      wptr_ff <= PTR_ZERO;
    end else begin
      wptr_ff <= nxt_wptr;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  reg  [ADDR_W-1:0] rptr_ff;
  reg  [ADDR_W-1:0] nxt_rptr;
  reg               read_pointer_reset_pend_ff;
  reg               nxt_read_pointer_reset_pend;
  reg  [DATA_W-1:0] rdata_ff;
  reg  [DATA_W-1:0] nxt_rdata;
  reg               roe_ff;
  reg               nxt_roe;
  reg  [ADDR_W-1:0] fetch_addr;
  wire [DATA_W-1:0] fetch_data;

  // Read pointer, deferred reset and output word decode
  always @* begin
    nxt_rptr      = rptr_ff;
    nxt_read_pointer_reset_pend = read_pointer_reset_pend_ff;
    nxt_rdata     = rdata_ff;
    nxt_roe       = roe_ff;
    fetch_addr    = rptr_ff + PTR_STEP;
    if (rd_edge) begin
      nxt_roe = roe_act;
      if (rgate_act) begin
        if (read_pointer_reset_act || read_pointer_reset_pend_ff) begin
          fetch_addr    = PTR_ZERO;
          nxt_rptr      = PTR_ZERO;
          nxt_rdata     = fetch_data;
          nxt_read_pointer_reset_pend = 1'b0;
        end else begin
          nxt_rptr  = rptr_ff + PTR_STEP;
          nxt_rdata = fetch_data;
        end
      end else begin
        if (read_pointer_reset_act) begin
          nxt_read_pointer_reset_pend = 1'b1;
        end
        nxt_rptr  = rptr_ff;
        nxt_rdata = rdata_ff;
      end
    end
  end

  // Read side registers
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      rptr_ff      <= PTR_ZERO;
      read_pointer_reset_pend_ff <= 1'b0;
      rdata_ff     <= `FMP_DATA_RST;
      roe_ff       <= 1'b0;
    end else begin
      rptr_ff      <= nxt_rptr;
      read_pointer_reset_pend_ff <= nxt_read_pointer_reset_pend;
      rdata_ff     <= nxt_rdata;
      roe_ff       <= nxt_roe;
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  fmp_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_in      (clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (wptr_ff),
    .wr_data_in  (wdata_s),
    .rd_addr_in  (fetch_addr),
    .rd_data_out (fetch_data)
  );

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  wire [ADDR_W-1:0] fill = wptr_ff - rptr_ff;
  wire              space_act;
  wire              data_act;
  reg               space_pin_ff;
  reg               data_pin_ff;

  // Flags report pointer distance only; they never stall a port
  assign space_act = ~(&fill);
  assign data_act  = |fill;

  // Flag pins in the strap-selected polarity
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      space_pin_ff <= ~`FMP_STRAP_RST;
      data_pin_ff  <= `FMP_STRAP_RST;
    end else begin
      space_pin_ff <= space_act ^ act_low;
      data_pin_ff  <= data_act ^ act_low;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data_out          = rdata_ff;
  assign rd_data_oe_b_out     = roe_ff ? 1'b0 : `FMP_OE_B_IDLE;
  assign input_space_flag_out = space_pin_ff;
  assign output_data_flag_out = data_pin_ff;

endmodule

// ==== rtl/fmp_mem.v ====
`timescale 1ns/1ps
`include "fmp_regs.vh"

module fmp_mem #(
  parameter DATA_W = `FMP_DATA_W,
  parameter ADDR_W = `FMP_ADDR_W
) (
  input  wire              clk_in,    // System clock
  input  wire              wr_en_in,  // Store strobe, one cycle
  input  wire [ADDR_W-1:0] wr_addr_in, // Store index
  input  wire [DATA_W-1:0] wr_data_in, // Store data
  input  wire [ADDR_W-1:0] rd_addr_in, // Fetch index
  output wire [DATA_W-1:0] rd_data_out // Fetch data, combinational
);

  localparam DEPTH = 1 << ADDR_W;

  reg [DATA_W-1:0] mem_ff [0:DEPTH-1];

  // Byte store; old contents kept when not strobed
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_ff[wr_addr_in] <= wr_data_in;
    end
  end

  // Indexed fetch
  assign rd_data_out = mem_ff[rd_addr_in];

endmodule

// ==== rtl/fmp_regs.vh ====
`ifndef FMP_REGS_VH
`define FMP_REGS_VH

// Default storage geometry: 512 kbytes of 8-bit words
`define FMP_DATA_W        8
`define FMP_ADDR_W        19

// Pointer value after a pointer reset
`define FMP_PTR_ZERO      19'h00000
// Pointer step on each gated clock edge
`define FMP_PTR_STEP      19'h00001

// Output data value after chip reset
`define FMP_DATA_RST      8'h00

// Strap level that selects active-low control and flag pins
`define FMP_STRAP_ACT_LOW 1'b1
// Strap level assumed at reset (pulled high when left open)
`define FMP_STRAP_RST     1'b1

// Synchroniser reset level
`define FMP_SYNC_RST      1'b0
// Cycles after reset before pin levels are trusted (two sync stages plus edge stage)
`define FMP_SETTLE_LEN    3

// Output enable of the data pins while not driving
`define FMP_OE_B_IDLE     1'b1

`endif

// ==== rtl/fmp_sync.v ====
`timescale 1ns/1ps
`include "fmp_regs.vh"

module fmp_sync #(
  parameter W = 1
) (
  input  wire         clk_in,   // System clock
  input  wire         rst_b_in, // Synchronous reset, active low
  input  wire [W-1:0] d_in,     // Asynchronous levels
  output wire [W-1:0] q_out     // Levels after two flops
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // Two-flop chain; first stage feeds only the second
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_ff <= {W{`FMP_SYNC_RST}};
      sync_ff <= {W{`FMP_SYNC_RST}};
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;

endmodule

// ==== testbench/fmp_field_fifo_properties.sv ====
`timescale 1ns/1ps
module fmp_field_fifo_properties #(
  parameter DATA_W = 8,
  parameter ADDR_W = 19
) (
  input wire              clk_in,                 // Clock
  input wire              rst_b_in,               // Reset
  input wire              polarity_strap_in,      // Strap
  input wire              write_clock_in,         // Pin
  input wire              write_pointer_reset_in, // Pin
  input wire              write_gate_in,          // Pin
  input wire              input_store_enable_in,  // Pin
  input wire [DATA_W-1:0] wr_data_in,             // Pins
  input wire              read_clock_in,          // Pin
  input wire              read_pointer_reset_in,  // Pin
  input wire              read_gate_in,           // Pin
  input wire              output_enable_in,       // Pin
  input wire [DATA_W-1:0] rd_data_out,            // Pins
  input wire              rd_data_oe_b_out,       // Pin
  input wire              input_space_flag_out,   // Pin
  input wire              output_data_flag_out    // Pin
);
  reg  [3:0] rcnt_ff, wcnt_ff, age_ff;
  reg        rck_ff, wck_ff;
  wire       live = (age_ff == 4'hf);
  wire       rg_on = read_gate_in ^ polarity_strap_in;
  wire       oe_on = output_enable_in ^ polarity_strap_in;
  wire       wg_on = write_gate_in ^ polarity_strap_in;
  wire       wr_on = write_pointer_reset_in ^ polarity_strap_in;
  wire       r_near = (rcnt_ff >= 4'h1) && (rcnt_ff <= 4'h7);
  wire       w_near = (wcnt_ff >= 4'h1) && (wcnt_ff <= 4'h7);
  // Cycles since each port clock rise and since reset
  always @(posedge clk_in) begin
    rck_ff <= read_clock_in;
    wck_ff <= write_clock_in;
    rcnt_ff <= (!rst_b_in) ? 4'hf : (read_clock_in && !rck_ff) ? 4'h0 : (rcnt_ff == 4'hf) ? rcnt_ff : rcnt_ff + 4'h1;
    wcnt_ff <= (!rst_b_in) ? 4'hf : (write_clock_in && !wck_ff) ? 4'h0 : (wcnt_ff == 4'hf) ? wcnt_ff : wcnt_ff + 4'h1;
    age_ff <= (!rst_b_in) ? 4'h0 : live ? age_ff : age_ff + 4'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_rd_edge;
    live && read_clock_in && !rck_ff;
  endsequence
  sequence s_wr_idle_edge;
    live && write_clock_in && !wck_ff && !wg_on && !wr_on && rcnt_ff == 4'hf;
  endsequence
  chk_data_at_edge: assert property ($changed(rd_data_out) && live |-> r_near)
    else $error("read data moved without read clock");
  chk_oe_at_edge: assert property ($changed(rd_data_oe_b_out) && live |-> r_near)
    else $error("output enable moved without read clock");
  chk_oe_drives: assert property (s_rd_edge ##0 oe_on |-> ##[2:6] !rd_data_oe_b_out)
    else $error("data pins not driven");
  chk_oe_floats: assert property (s_rd_edge ##0 !oe_on |-> ##[2:6] rd_data_oe_b_out)
    else $error("data pins not floated");
  chk_hold_no_gate: assert property (s_rd_edge ##0 !rg_on |-> ($stable(rd_data_out))[*7])
    else $error("read output moved with gate off");
  chk_data_flag_edge: assert property ($changed(output_data_flag_out) && live |-> r_near || w_near)
    else $error("data flag moved without port clock");
  chk_space_flag_edge: assert property ($changed(input_space_flag_out) && live |-> r_near || w_near)
    else $error("space flag moved without port clock");
  chk_write_gate_off: assert property (s_wr_idle_edge |-> ($stable(output_data_flag_out))[*7])
    else $error("write pointer moved with gate off");
endmodule

bind fmp_field_fifo fmp_field_fifo_properties #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_u (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .polarity_strap_in(polarity_strap_in),
  .write_clock_in(write_clock_in), .write_pointer_reset_in(write_pointer_reset_in),
  .write_gate_in(write_gate_in), .input_store_enable_in(input_store_enable_in), .wr_data_in(wr_data_in),
  .read_clock_in(read_clock_in), .read_pointer_reset_in(read_pointer_reset_in), .read_gate_in(read_gate_in),
  .output_enable_in(output_enable_in), .rd_data_out(rd_data_out), .rd_data_oe_b_out(rd_data_oe_b_out),
  .input_space_flag_out(input_space_flag_out), .output_data_flag_out(output_data_flag_out));

// ==== testbench/fmp_port_drv.sv ====
`timescale 1ns/1ps
module fmp_port_drv (
  input  wire       clk_in,   // Bench clock
  input  wire       strap_in, // High: controls active low
  output wire       pclk_out, // Port clock
  output wire       rst_out,  // Pointer reset pin
  output wire       gate_out, // Gate pin
  output wire       aux_out,  // Store or output enable pin
  output wire [7:0] data_out  // Write data pins
);
  reg       pclk_ff = 1'b0;
  reg       rst_ff = 1'b0;
  reg       gate_ff = 1'b0;
  reg       aux_ff = 1'b0;
  reg [7:0] data_ff = 8'h00;
  // Logical levels turned into pin levels
  assign pclk_out = pclk_ff;
  assign rst_out  = rst_ff ^ strap_in;
  assign gate_out = gate_ff ^ strap_in;
  assign aux_out  = aux_ff ^ strap_in;
  assign data_out = data_ff;
  // One port clock cycle; clock idles low between cycles
  task cyc(input [2:0] c, input [7:0] d);
    begin
      @(negedge clk_in);
      {rst_ff, gate_ff, aux_ff} = c;
      data_ff = d;
      repeat (4) @(negedge clk_in);
      pclk_ff = 1'b1;
      repeat (6) @(negedge clk_in);
      pclk_ff = 1'b0;
      data_ff = ~d;
    end
  endtask
endmodule

// ==== testbench/test_fmp_field_fifo.sv ====
`timescale 1ns/1ps
module test_fmp_field_fifo;
  reg        clk_in = 1'b0;
  reg        rst_b_in = 1'b0;
  reg        polarity_strap_in = 1'b1;
  wire       write_clock, write_pointer_reset, wgate, wstore, read_clock, read_pointer_reset, rgate, roe;
  wire       rd_data_oe_b_out, input_space_flag_out, output_data_flag_out;
  wire [7:0] wdata, rd_data_out;
  integer    n_errors = 0;
  integer    check_count = 0;
  integer    pass;
  always #2 clk_in = ~clk_in;
  // Source on the write port, sink on the read port
  fmp_port_drv w_u (.clk_in(clk_in), .strap_in(polarity_strap_in), .pclk_out(write_clock), .rst_out(write_pointer_reset),
    .gate_out(wgate), .aux_out(wstore), .data_out(wdata));
  fmp_port_drv r_u (.clk_in(clk_in), .strap_in(polarity_strap_in), .pclk_out(read_clock), .rst_out(read_pointer_reset),
    .gate_out(rgate), .aux_out(roe), .data_out());
  fmp_field_fifo #(.ADDR_W(6)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .polarity_strap_in(polarity_strap_in), .write_clock_in(write_clock), .write_pointer_reset_in(write_pointer_reset),
    .write_gate_in(wgate), .input_store_enable_in(wstore), .wr_data_in(wdata), .read_clock_in(read_clock),
    .read_pointer_reset_in(read_pointer_reset), .read_gate_in(rgate), .output_enable_in(roe), .rd_data_out(rd_data_out),
    .rd_data_oe_b_out(rd_data_oe_b_out), .input_space_flag_out(input_space_flag_out),
    .output_data_flag_out(output_data_flag_out));
  // Pin level of an asserted or idle flag
  function automatic logic fl(input logic a);
    fl = a ^ polarity_strap_in;
  endfunction
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chip_reset(input logic s);
    begin
      @(negedge clk_in);
      rst_b_in = 1'b0;
      polarity_strap_in = s;
      repeat (10) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (5) @(negedge clk_in);
    end
  endtask
  // Pointer resets on both ports
  task s_init;
    begin
      w_u.cyc(3'b100, 8'h00);
      r_u.cyc(3'b111, 8'h00);
      chk1("oe_b", 1'b0, rd_data_oe_b_out);
      chk1("data_flag", fl(1'b0), output_data_flag_out);
      chk1("space_flag", fl(1'b1), input_space_flag_out);
    end
  endtask
  // Store, mask, gate off, then read back
  task s_store;
    reg [7:0] i;
    begin
      for (i = 8'h00; i < 8'h04; i = i + 8'h01) w_u.cyc(3'b011, 8'ha0 + i);
      w_u.cyc(3'b111, 8'h00);
      w_u.cyc(3'b011, 8'hb0);
      w_u.cyc(3'b010, 8'hb1);
      w_u.cyc(3'b001, 8'hee);
      w_u.cyc(3'b011, 8'hb2);
      r_u.cyc(3'b111, 8'h00);
      chk8("word0", 8'hb0, rd_data_out);
      r_u.cyc(3'b011, 8'h00);
      chk8("word1", 8'ha1, rd_data_out);
      r_u.cyc(3'b001, 8'h00);
      chk8("held", 8'ha1, rd_data_out);
      r_u.cyc(3'b011, 8'h00);
      chk8("word2", 8'hb2, rd_data_out);
      chk1("data_flag", fl(1'b1), output_data_flag_out);
      r_u.cyc(3'b010, 8'h00);
      chk1("oe_b", 1'b1, rd_data_oe_b_out);
      chk1("data_flag", fl(1'b0), output_data_flag_out);
    end
  endtask
  // Read reset with gate off waits for the gate
  task s_defer;
    begin
      r_u.cyc(3'b000, 8'h00);
      chk1("oe_b", 1'b1, rd_data_oe_b_out);
      chk8("held", 8'ha3, rd_data_out);
      r_u.cyc(3'b101, 8'h00);
      chk8("held", 8'ha3, rd_data_out);
      chk1("oe_b", 1'b0, rd_data_oe_b_out);
      chk1("data_flag", fl(1'b0), output_data_flag_out);
      r_u.cyc(3'b011, 8'h00);
      chk8("word0", 8'hb0, rd_data_out);
      chk1("data_flag", fl(1'b1), output_data_flag_out);
    end
  endtask
  // Fill to the last free place, then free one
  task s_space;
    reg [7:0] i;
    begin
      r_u.cyc(3'b110, 8'h00);
      chk1("oe_b", 1'b1, rd_data_oe_b_out);
      w_u.cyc(3'b100, 8'h00);
      for (i = 8'h00; i < 8'h3f; i = i + 8'h01) w_u.cyc(3'b011, i);
      chk1("space_flag", fl(1'b0), input_space_flag_out);
      r_u.cyc(3'b011, 8'h00);
      chk8("word1", 8'h01, rd_data_out);
      chk1("space_flag", fl(1'b1), input_space_flag_out);
    end
  endtask
  initial begin
    for (pass = 0; pass < 2; pass = pass + 1) begin
      chip_reset(pass == 0);
      s_init;
      s_store;
      s_defer;
      s_space;
    end
    stop_test;
  end
  // Watchdog well beyond both passes
  initial begin
    #40000;
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule
